/* File: gsc_params.svh */
// Named constants for the generator synchronizer control block
`ifndef GSC_PARAMS_SVH
`define GSC_PARAMS_SVH
// ============================================================
// Register byte offsets
`define GSC_OFF_CTRL 8'h00
`define GSC_OFF_LIM_V 8'h04
`define GSC_OFF_LIM_F 8'h08
`define GSC_OFF_LIM_A 8'h0C
`define GSC_OFF_VBASE 8'h10
`define GSC_OFF_FBASE 8'h14
`define GSC_OFF_PRECL 8'h18
`define GSC_OFF_SYNCT 8'h1C
`define GSC_OFF_STILL 8'h20
`define GSC_OFF_STAT 8'h24
`define GSC_OFF_LEFT 8'h28
// ============================================================
// Control register bit positions
`define GSC_CTRL_START 0
`define GSC_CTRL_STOP 1
`define GSC_CTRL_POS 2
`define GSC_CTRL_BLK 3
// ============================================================
// Reset values of the settings
`define GSC_RST_LIM_V 16'h0100
`define GSC_RST_LIM_F 16'h0007
`define GSC_RST_LIM_A 16'h0222
`define GSC_RST_VBASE 16'h00C8
`define GSC_RST_FBASE 16'h00C8
`define GSC_RST_PRECL 16'h0032
`define GSC_RST_SYNCT 32'h0001D4C0
`define GSC_RST_STILL 16'h0001
// ============================================================
// Timing: one tick is one millisecond
`define GSC_CLK_NS 4
`define GSC_TICK_NS 1000000
`define GSC_TICK_CYC (`GSC_TICK_NS / `GSC_CLK_NS)
`define GSC_CLOSE_MS 16'h0064
`define GSC_SCALE_SH 6
// ============================================================
// Bus answers
`define GSC_RESP_OKAY 2'h0
`define GSC_RESP_SLVERR 2'h2
`endif

/* File: gsc_pkg.sv */
// Types shared by the generator synchronizer control block
package gsc_pkg;
	// One side's measurement: magnitude, frequency in angle units per ms, binary angle
	typedef struct packed {
		logic [15:0] mag;
		logic signed [15:0] freq;
		logic signed [15:0] ang;
	} gsc_meas_s;
	typedef enum logic [1:0] {GSC_CONF_ERR, GSC_IDLE, GSC_SYNC, GSC_BLOCKED} gsc_state_e;
	typedef enum logic [1:0] {GSC_STILL, GSC_DEPART, GSC_ENCLOSE} gsc_rot_e;
	typedef enum logic [1:0] {GSC_P_IDLE, GSC_P_DRIVE, GSC_P_PAUSE} gsc_pulse_e;
endpackage

/* File: gsc_sync_ctrl.sv */
// Generator synchronizer: AXI4-Lite settings, correction pulses and breaker close
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "gsc_params.svh"

// ============================================================
// Raise/lower pulse generator with error-scaled length and pause
module gsc_pulser #(
	parameter int SH = `GSC_SCALE_SH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Control
	input wire logic tick,
	input wire logic en,
	input wire logic need,
	input wire logic up,
	input wire logic [15:0] base,
	input wire logic [15:0] diff,
	// Commands
	output logic raise_q,
	output logic lower_q
);
	import gsc_pkg::*;
	gsc_pulse_e ph_q, ph_d;
	logic [19:0] cnt_q, cnt_d;
	logic up_q, dir_d, done;
	logic [31:0] prod;
	logic [19:0] len;

	// Base length stretched in proportion to the error
	assign prod = 32'(diff) * 32'(base);
	assign len = 20'(32'(base) + (prod >> SH));
	assign done = tick && (cnt_q <= 20'h00001);
	assign dir_d = (ph_q == GSC_P_IDLE) ? up : up_q;

	// Drive, then wait one base length so the regulator can respond
	always_comb begin
		ph_d = ph_q;
		cnt_d = cnt_q;
		if (tick && cnt_q != 20'h00000) cnt_d = cnt_q - 20'h00001;
		case (ph_q)
			GSC_P_IDLE: if (en && need) begin
				ph_d = GSC_P_DRIVE;
				cnt_d = len;
			end
			GSC_P_DRIVE: if (!en) begin
				ph_d = GSC_P_IDLE;
			end else if (done) begin
				ph_d = GSC_P_PAUSE;
				cnt_d = 20'(base);
			end
			GSC_P_PAUSE: if (!en || done) begin
				ph_d = GSC_P_IDLE;
			end
			default: ph_d = GSC_P_IDLE;
		endcase
	end

	// Phase, count and registered commands
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ph_q <= GSC_P_IDLE;
			cnt_q <= 20'h00000;
			up_q <= 1'b0;
			raise_q <= 1'b0;
			lower_q <= 1'b0;
		end else begin
			ph_q <= ph_d;
			cnt_q <= cnt_d;
			up_q <= dir_d;
			raise_q <= (ph_d == GSC_P_DRIVE) && dir_d;
			lower_q <= (ph_d == GSC_P_DRIVE) && !dir_d;
		end
	end

	a_pulse_gated: assert property (@(posedge clk) disable iff (!nrst)
		!en |=> !raise_q && !lower_q) else $error("pulse while disabled");
	a_pulse_dir: assert property (@(posedge clk) disable iff (!nrst)
		$rose(raise_q) |-> $past(up) && $past(need)) else $error("raise against direction");
	a_pulse_excl: assert property (@(posedge clk) disable iff (!nrst)
		!(raise_q && lower_q)) else $error("raise and lower together");
endmodule

// ============================================================
// Summary of operation
// - Sample one voltage from each side of the breaker for all decisions.
// - Hold frequency, angle and fundamental magnitude for each selected channel.
// - Raise or lower voltage commands reduce the magnitude difference.
// - Voltage pulse base length is set and scaled by magnitude difference.
// - Raise or lower frequency commands to the governor reduce slip.
// - Frequency pulse length set separately, scaled by frequency difference.
// - Optional positive-slip-only mode prevents closing under reverse power.
// - Close only when magnitude, frequency and predicted closing angle are all within limits.
// - Close command is advanced by a set pre-closing time.
// - Closing angle is derived from slip and pre-closing time.
// - Three ok outputs: magnitude, frequency and angle within limit.
// - Outputs: blocked, running, raise/lower, close, long sync, rotation.
// - Overall status: configuration error, idle, synchronizing or blocked.
// - Report net rotation as standstill, departing or enclosing.
// - Count down sync time from start; flag long sync on expiry.
module gsc_sync_ctrl #(
	parameter int AW = 8,
	parameter int unsigned TICK_CYC = `GSC_TICK_CYC
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic NRST,
	// Measurement front end
	input wire gsc_pkg::gsc_meas_s MEAS_GEN,
	input wire gsc_pkg::gsc_meas_s MEAS_GRID,
	input wire logic MEAS_VLD,
	// External block pin
	input wire logic BLOCK_IN,
	// AXI4-Lite write
	input wire logic [AW-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// AXI4-Lite read
	input wire logic [AW-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// Status
	output logic VOLT_OK,
	output logic FREQ_OK,
	output logic ANGLE_OK,
	output logic BLOCKED,
	output logic RUNNING,
	output logic LONG_SYNC,
	// Regulator, governor and breaker commands
	output logic RAISE_V,
	output logic LOWER_V,
	output logic RAISE_F,
	output logic LOWER_F,
	output logic BRK_CLOSE,
	// Net rotation
	output logic NET_STILL,
	output logic NET_DEPART,
	output logic NET_ENCLOSE
);
	import gsc_pkg::*;

	// Saturating magnitude of a signed difference
	function automatic logic [15:0] mag16(input logic signed [16:0] v);
		logic [16:0] a;
		a = v[16] ? 17'(-v) : 17'(v);
		mag16 = a[16] ? 16'hFFFF : a[15:0];
	endfunction

	// Byte-lane merge of a write
	function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
		mrg = {s[3] ? d[31:24] : o[31:24], s[2] ? d[23:16] : o[23:16],
			s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
	endfunction

	gsc_state_e st_q, st_d;
	gsc_rot_e rot_q, rot_d;
	gsc_meas_s gen_q, grid_q;
	logic [31:0] tick_cnt_q;
	logic tick_q, blk_s1_q, blk_s2_q, pos_q, sw_blk_q, closed_q;
	logic [15:0] lim_v_q, lim_f_q, lim_a_q, vbase_q, fbase_q, precl_q, still_q, ccnt_q;
	logic [31:0] synct_q, left_q;
	logic [AW-1:0] awa_q;
	logic [31:0] wd_q, rd_mux;
	logic [3:0] ws_q;

	// ============================================================
	// Millisecond tick and block pin synchroniser
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			tick_cnt_q <= 32'h00000000;
			tick_q <= 1'b0;
			blk_s1_q <= 1'b0;
			blk_s2_q <= 1'b0;
		end else begin
			tick_q <= (tick_cnt_q == 32'(TICK_CYC - 1));
			tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYC - 1)) ? 32'h00000000 : tick_cnt_q + 32'h00000001;
			blk_s1_q <= BLOCK_IN;
			blk_s2_q <= blk_s1_q;
		end
	end

	// Latest sample of each side of the breaker
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			gen_q <= '0;
			grid_q <= '0;
		end else if (MEAS_VLD) begin
			gen_q <= MEAS_GEN;
			grid_q <= MEAS_GRID;
		end
	end

	// ============================================================
	// Differences, limits and predicted closing angle
	logic signed [16:0] dmag_s, slip_s;
	logic signed [15:0] ang_s, pred_s;
	logic signed [33:0] adv_s;
	logic [15:0] dm_abs, sl_abs, an_abs, pr_abs;
	logic v_in, f_in, a_in, win, conf_err, blk_now, close_go, go, en_p;
	assign dmag_s = $signed({1'b0, gen_q.mag}) - $signed({1'b0, grid_q.mag});
	assign slip_s = $signed({gen_q.freq[15], gen_q.freq}) - $signed({grid_q.freq[15], grid_q.freq});
	assign ang_s = gen_q.ang - grid_q.ang;
	assign adv_s = slip_s * $signed({1'b0, precl_q});
	assign pred_s = ang_s + $signed(adv_s[15:0]);
	assign dm_abs = mag16(dmag_s);
	assign sl_abs = mag16(slip_s);
	assign an_abs = mag16({ang_s[15], ang_s});
	assign pr_abs = mag16({pred_s[15], pred_s});
	assign v_in = dm_abs <= lim_v_q;
	assign f_in = (sl_abs <= lim_f_q) && (!pos_q || slip_s > 17'sh00000);
	assign a_in = an_abs <= lim_a_q;
	assign win = pr_abs <= lim_a_q;
	assign conf_err = (lim_v_q == 16'h0000) || (lim_f_q == 16'h0000) || (lim_a_q == 16'h0000) ||
		(vbase_q == 16'h0000) || (fbase_q == 16'h0000);
	assign blk_now = sw_blk_q || blk_s2_q;
	assign close_go = (st_q == GSC_SYNC) && v_in && f_in && win && !closed_q && !blk_now;
	assign go = (st_q == GSC_IDLE) && (st_d == GSC_SYNC);
	assign en_p = (st_q == GSC_SYNC) && !closed_q;

	// ============================================================
	// Bus write decode
	logic wr_go, hit_w, rd_hit, start_w, stop_w, w_ctrl;
	assign wr_go = !AWREADY && !WREADY && !BVALID;
	assign w_ctrl = wr_go && awa_q == AW'(`GSC_OFF_CTRL) && ws_q[0];
	assign start_w = w_ctrl && wd_q[`GSC_CTRL_START];
	assign stop_w = w_ctrl && wd_q[`GSC_CTRL_STOP];
	assign hit_w = awa_q == AW'(`GSC_OFF_CTRL) || awa_q == AW'(`GSC_OFF_LIM_V) || awa_q == AW'(`GSC_OFF_LIM_F) ||
		awa_q == AW'(`GSC_OFF_LIM_A) || awa_q == AW'(`GSC_OFF_VBASE) || awa_q == AW'(`GSC_OFF_FBASE) ||
		awa_q == AW'(`GSC_OFF_PRECL) || awa_q == AW'(`GSC_OFF_SYNCT) || awa_q == AW'(`GSC_OFF_STILL) ||
		awa_q == AW'(`GSC_OFF_STAT) || awa_q == AW'(`GSC_OFF_LEFT);

	// Bus read selection
	assign rd_mux = (ARADDR == AW'(`GSC_OFF_CTRL)) ? {28'h0000000, sw_blk_q, pos_q, 2'h0} :
		(ARADDR == AW'(`GSC_OFF_LIM_V)) ? {16'h0000, lim_v_q} :
		(ARADDR == AW'(`GSC_OFF_LIM_F)) ? {16'h0000, lim_f_q} :
		(ARADDR == AW'(`GSC_OFF_LIM_A)) ? {16'h0000, lim_a_q} :
		(ARADDR == AW'(`GSC_OFF_VBASE)) ? {16'h0000, vbase_q} :
		(ARADDR == AW'(`GSC_OFF_FBASE)) ? {16'h0000, fbase_q} :
		(ARADDR == AW'(`GSC_OFF_PRECL)) ? {16'h0000, precl_q} :
		(ARADDR == AW'(`GSC_OFF_SYNCT)) ? synct_q :
		(ARADDR == AW'(`GSC_OFF_STILL)) ? {16'h0000, still_q} :
		(ARADDR == AW'(`GSC_OFF_STAT)) ? {23'h000000, closed_q, rot_q, LONG_SYNC, ANGLE_OK, FREQ_OK, VOLT_OK, st_q} :
		(ARADDR == AW'(`GSC_OFF_LEFT)) ? left_q : 32'h00000000;
	assign rd_hit = (ARADDR[1:0] == 2'h0) && (ARADDR <= AW'(`GSC_OFF_LEFT));

	// Write address and data capture, response after both
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			AWREADY <= 1'b1;
			WREADY <= 1'b1;
			BVALID <= 1'b0;
			BRESP <= `GSC_RESP_OKAY;
			awa_q <= '0;
			wd_q <= 32'h00000000;
			ws_q <= 4'h0;
		end else begin
			if (AWVALID && AWREADY) begin
				AWREADY <= 1'b0;
				awa_q <= AWADDR;
			end
			if (WVALID && WREADY) begin
				WREADY <= 1'b0;
				wd_q <= WDATA;
				ws_q <= WSTRB;
			end
			if (wr_go) begin
				BVALID <= 1'b1;
				BRESP <= hit_w ? `GSC_RESP_OKAY : `GSC_RESP_SLVERR;
			end
			if (BVALID && BREADY) begin
				BVALID <= 1'b0;
				AWREADY <= 1'b1;
				WREADY <= 1'b1;
			end
		end
	end

	// Read channel: answer one cycle after the address is taken
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			ARREADY <= 1'b1;
			RVALID <= 1'b0;
			RDATA <= 32'h00000000;
			RRESP <= `GSC_RESP_OKAY;
		end else if (ARVALID && ARREADY) begin
			ARREADY <= 1'b0;
			RVALID <= 1'b1;
			RDATA <= rd_mux;
			RRESP <= rd_hit ? `GSC_RESP_OKAY : `GSC_RESP_SLVERR;
		end else if (RVALID && RREADY) begin
			RVALID <= 1'b0;
			ARREADY <= 1'b1;
		end
	end

	// Settings registers
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			pos_q <= 1'b0;
			sw_blk_q <= 1'b0;
			lim_v_q <= `GSC_RST_LIM_V;
			lim_f_q <= `GSC_RST_LIM_F;
			lim_a_q <= `GSC_RST_LIM_A;
			vbase_q <= `GSC_RST_VBASE;
			fbase_q <= `GSC_RST_FBASE;
			precl_q <= `GSC_RST_PRECL;
			synct_q <= `GSC_RST_SYNCT;
			still_q <= `GSC_RST_STILL;
		end else if (wr_go) begin
			if (w_ctrl) pos_q <= wd_q[`GSC_CTRL_POS];
			if (w_ctrl) sw_blk_q <= wd_q[`GSC_CTRL_BLK];
			if (awa_q == AW'(`GSC_OFF_LIM_V)) lim_v_q <= 16'(mrg(32'(lim_v_q), wd_q, ws_q));
			if (awa_q == AW'(`GSC_OFF_LIM_F)) lim_f_q <= 16'(mrg(32'(lim_f_q), wd_q, ws_q));
			if (awa_q == AW'(`GSC_OFF_LIM_A)) lim_a_q <= 16'(mrg(32'(lim_a_q), wd_q, ws_q));
			if (awa_q == AW'(`GSC_OFF_VBASE)) vbase_q <= 16'(mrg(32'(vbase_q), wd_q, ws_q));
			if (awa_q == AW'(`GSC_OFF_FBASE)) fbase_q <= 16'(mrg(32'(fbase_q), wd_q, ws_q));
			if (awa_q == AW'(`GSC_OFF_PRECL)) precl_q <= 16'(mrg(32'(precl_q), wd_q, ws_q));
			if (awa_q == AW'(`GSC_OFF_SYNCT)) synct_q <= mrg(synct_q, wd_q, ws_q);
			if (awa_q == AW'(`GSC_OFF_STILL)) still_q <= 16'(mrg(32'(still_q), wd_q, ws_q));
		end
	end

	// ============================================================
	// Overall state: configuration error, idle, synchronizing, blocked
	always_comb begin
		st_d = st_q;
		if (conf_err) begin
			st_d = GSC_CONF_ERR;
		end else if (blk_now) begin
			st_d = GSC_BLOCKED;
		end else begin
			case (st_q)
				GSC_CONF_ERR: st_d = GSC_IDLE;
				GSC_BLOCKED: st_d = GSC_IDLE;
				GSC_IDLE: if (start_w) st_d = GSC_SYNC;
				GSC_SYNC: if (stop_w || (closed_q && !BRK_CLOSE)) st_d = GSC_IDLE;
				default: st_d = GSC_IDLE;
			endcase
		end
	end

	// Net rotation from slip size and angle trend
	assign rot_d = (sl_abs < still_q) ? GSC_STILL :
		((ang_s != 16'sh0000 && ang_s[15] != slip_s[16]) ? GSC_ENCLOSE : GSC_DEPART);

	// State, timer, close pulse and flags
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			st_q <= GSC_IDLE;
			rot_q <= GSC_STILL;
			left_q <= 32'h00000000;
			closed_q <= 1'b0;
			ccnt_q <= 16'h0000;
		end else begin
			st_q <= st_d;
			rot_q <= rot_d;
			if (go) left_q <= synct_q;
			else if (st_q == GSC_SYNC && tick_q && left_q != 32'h00000000) left_q <= left_q - 32'h00000001;
			if (go) closed_q <= 1'b0;
			else if (close_go) closed_q <= 1'b1;
			if (close_go) ccnt_q <= `GSC_CLOSE_MS;
			else if (tick_q && ccnt_q != 16'h0000) ccnt_q <= ccnt_q - 16'h0001;
		end
	end

	// Registered outputs
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			{VOLT_OK, FREQ_OK, ANGLE_OK, BLOCKED, RUNNING, LONG_SYNC, BRK_CLOSE} <= 7'h00;
			{NET_STILL, NET_DEPART, NET_ENCLOSE} <= 3'h4;
		end else begin
			VOLT_OK <= v_in;
			FREQ_OK <= f_in;
			ANGLE_OK <= a_in;
			BLOCKED <= st_d == GSC_BLOCKED;
			RUNNING <= st_d == GSC_SYNC;
			LONG_SYNC <= !go && (LONG_SYNC || (st_q == GSC_SYNC && left_q == 32'h00000000));
			BRK_CLOSE <= (close_go || (BRK_CLOSE && !(tick_q && ccnt_q <= 16'h0001))) && !blk_now && !stop_w;
			NET_STILL <= rot_d == GSC_STILL;
			NET_DEPART <= rot_d == GSC_DEPART;
			NET_ENCLOSE <= rot_d == GSC_ENCLOSE;
		end
	end

	// Voltage and frequency correction pulses
	gsc_pulser #(.SH(`GSC_SCALE_SH)) u_volt (
		.clk(CLK_SYS), .nrst(NRST), .tick(tick_q), .en(en_p),
		.need(!v_in), .up(dmag_s < 17'sh00000), .base(vbase_q), .diff(dm_abs),
		.raise_q(RAISE_V), .lower_q(LOWER_V)
	);
	gsc_pulser #(.SH(`GSC_SCALE_SH)) u_freq (
		.clk(CLK_SYS), .nrst(NRST), .tick(tick_q), .en(en_p),
		.need(!f_in), .up(slip_s <= 17'sh00000), .base(fbase_q), .diff(sl_abs),
		.raise_q(RAISE_F), .lower_q(LOWER_F)
	);

	// ============================================================
	// Checks
	a_close_cond: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		$rose(BRK_CLOSE) |-> $past(v_in && f_in && win && st_q == GSC_SYNC)) else $error("close outside limits");
	a_close_once: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		$rose(BRK_CLOSE) |-> !$past(closed_q)) else $error("second close in one attempt");
	a_pos_slip: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		$rose(BRK_CLOSE) && $past(pos_q) |-> $past(slip_s > 17'sh00000)) else $error("close with negative slip");
	a_conf_err: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		conf_err |=> st_q == GSC_CONF_ERR && !RUNNING) else $error("config error not reported");
	a_long_sync: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		st_q == GSC_SYNC && left_q == 32'h00000000 |=> LONG_SYNC) else $error("long sync missing");
	a_block_close: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		blk_now && !conf_err |=> !BRK_CLOSE && BLOCKED) else $error("close while blocked");
	a_block_pulse: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		blk_now |-> ##2 !(RAISE_V || LOWER_V || RAISE_F || LOWER_F)) else $error("pulse while blocked");
	a_rot_onehot: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		$onehot({NET_STILL, NET_DEPART, NET_ENCLOSE})) else $error("rotation not one-hot");
	a_bus_resp: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		wr_go |=> BVALID && !AWREADY && !WREADY) else $error("write response missing");
endmodule

/* File: gsc_gen_model.sv */
// Behavioural generator, voltage regulator, speed governor and breaker seen by the synchronizer
`timescale 1ns/1ps
// ============================================================
// Generator model: regulator pulses move magnitude, governor pulses move speed
module gsc_gen_model (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Commands from the synchronizer
	input wire logic raise_v,
	input wire logic lower_v,
	input wire logic raise_f,
	input wire logic lower_f,
	input wire logic brk_close,
	// Operating point set by the bench
	input wire logic load,
	input wire gsc_pkg::gsc_meas_s init,
	// Generator-side sample and count of breaker closings
	output gsc_pkg::gsc_meas_s meas,
	output int n_close
);
	import gsc_pkg::*;
	logic [3:0] div_q = 4'h0;
	logic close_q = 1'b0;
	// Start from a known sample so the block never sees an unknown input
	initial begin
		meas = '0;
		n_close = 0;
	end
	// Regulator acts every second cycle, the slower governor once in sixteen
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meas <= '0;
			div_q <= 4'h0;
		end else if (load) begin
			meas <= init;
		end else begin
			div_q <= div_q + 4'h1;
			if (raise_v && div_q[0]) meas.mag <= meas.mag + 16'h0001;
			if (lower_v && div_q[0]) meas.mag <= meas.mag - 16'h0001;
			if (raise_f && div_q == 4'hF) meas.freq <= meas.freq + 16'sh0001;
			if (lower_f && div_q == 4'hF) meas.freq <= meas.freq - 16'sh0001;
		end
	end
	// Breaker counts each close command it receives
	always @(posedge clk) begin
		close_q <= brk_close;
		if (brk_close && !close_q) n_close <= n_close + 1;
	end
endmodule

/* File: test_generator_synchronizer_control.sv */
// Self-checking bench for the generator synchronizer control block
`timescale 1ns/1ps
`include "gsc_params.svh"
// ============================================================
// Bench top
module test_generator_synchronizer_control;
	import gsc_pkg::*;
	localparam int VOK = 0, FOK = 1, AOK = 2, BLK = 3, RUN = 4, LNG = 5, RV = 6, LV = 7, RF = 8, LF = 9, CLS = 10;
	localparam int STL = 11, DEP = 12, ENC = 13;
	localparam logic [13:0] CMDS = 14'h07C0;
	logic CLK_SYS = 1'b0, NRST = 1'b0, MEAS_VLD = 1'b1, BLOCK_IN = 1'b0, load = 1'b0;
	logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
	logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
	logic [31:0] WDATA = 32'h0;
	logic [3:0] WSTRB = 4'hF;
	gsc_meas_s MEAS_GRID = {16'h4000, 16'h0400, 16'h0000};
	gsc_meas_s MEAS_GEN, init = {16'h4000, 16'h0400, 16'h0000};
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, VOLT_OK, FREQ_OK, ANGLE_OK, BLOCKED, RUNNING, LONG_SYNC;
	logic RAISE_V, LOWER_V, RAISE_F, LOWER_F, BRK_CLOSE, NET_STILL, NET_DEPART, NET_ENCLOSE;
	logic [1:0] BRESP, RRESP;
	logic [31:0] RDATA;
	int n_errors = 0, compares = 0, cyc = 0, n_close;
	wire [13:0] outs = {NET_ENCLOSE, NET_DEPART, NET_STILL, BRK_CLOSE, LOWER_F, RAISE_F, LOWER_V, RAISE_V,
		LONG_SYNC, RUNNING, BLOCKED, ANGLE_OK, FREQ_OK, VOLT_OK};
	string nm[14] = '{"VOLT_OK", "FREQ_OK", "ANGLE_OK", "BLOCKED", "RUNNING", "LONG_SYNC", "RAISE_V", "LOWER_V",
		"RAISE_F", "LOWER_F", "BRK_CLOSE", "NET_STILL", "NET_DEPART", "NET_ENCLOSE"};
	// Block under test with a short millisecond tick, and its far-side model
	gsc_sync_ctrl #(.AW(8), .TICK_CYC(10)) gsc_sync_ctrl_i (
		.CLK_SYS, .NRST, .MEAS_GEN, .MEAS_GRID, .MEAS_VLD, .BLOCK_IN,
		.AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
		.ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
		.VOLT_OK, .FREQ_OK, .ANGLE_OK, .BLOCKED, .RUNNING, .LONG_SYNC, .RAISE_V, .LOWER_V, .RAISE_F, .LOWER_F,
		.BRK_CLOSE, .NET_STILL, .NET_DEPART, .NET_ENCLOSE);
	gsc_gen_model gsc_gen_model_i (.clk(CLK_SYS), .nrst(NRST), .raise_v(RAISE_V), .lower_v(LOWER_V),
		.raise_f(RAISE_F), .lower_f(LOWER_F), .brk_close(BRK_CLOSE), .load(load), .init(init),
		.meas(MEAS_GEN), .n_close(n_close));
	// 250 MHz clock
	initial forever #2 CLK_SYS = ~CLK_SYS;
	// Hang guard
	always @(posedge CLK_SYS) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			test_done;
		end
	end
	// ============================================================
	// Shared tasks
	task automatic test_done;
		if (n_errors == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		do begin
			@(posedge CLK_SYS);
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) WVALID <= 1'b0;
		end while (BVALID !== 1'b1);
		BREADY <= 1'b0;
		chk("BRESP", 32'(er), 32'(BRESP));
		@(posedge CLK_SYS);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er = 2'h0);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do begin
			@(posedge CLK_SYS);
			if (ARREADY) ARVALID <= 1'b0;
		end while (RVALID !== 1'b1);
		RREADY <= 1'b0;
		chk("RDATA", e, RDATA & m);
		chk("RRESP", 32'(er), 32'(RRESP));
		@(posedge CLK_SYS);
	endtask
	task automatic wait_bit(input int i, input logic v, input int lim);
		int n;
		for (n = 0; n < lim && outs[i] !== v; n++) @(posedge CLK_SYS);
		chk(nm[i], 32'(v), 32'(outs[i]));
	endtask
	task automatic quiet(input logic [13:0] m, input int c);
		logic [13:0] seen;
		seen = '0;
		repeat (c) begin
			@(posedge CLK_SYS);
			seen = seen | (outs & m);
		end
		chk("outputs held low", 32'h0, 32'(seen));
	endtask
	task automatic plen(input int i, input int lo, input int hi);
		int n;
		n = 0;
		while (outs[i] === 1'b1 && n < 2000) begin
			@(posedge CLK_SYS);
			n++;
		end
		chk({nm[i], " length in range"}, 32'h1, 32'(n >= lo && n <= hi));
	endtask
	task automatic set_gen(input logic [15:0] dm, input logic [15:0] df, input logic [15:0] da);
		init <= {MEAS_GRID.mag + dm, MEAS_GRID.freq + df, MEAS_GRID.ang + da};
		load <= 1'b1;
		@(posedge CLK_SYS);
		load <= 1'b0;
		@(posedge CLK_SYS);
	endtask
	// ============================================================
	// Scenarios
	task automatic t_regs;
		logic [31:0] e[8] = '{32'h100, 32'h7, 32'h222, 32'hC8, 32'hC8, 32'h32, 32'h1D4C0, 32'h1};
		for (int k = 0; k < 8; k++) rd(8'h04 + 8'(4 * k), 32'hFFFFFFFF, e[k]);
		wr(`GSC_OFF_CTRL, 32'hF);
		rd(`GSC_OFF_CTRL, 32'hFFFFFFFF, 32'hC);
		wr(`GSC_OFF_CTRL, 32'h0);
		wr(`GSC_OFF_STAT, 32'h0);
		rd(8'h2C, 32'hFFFFFFFF, 32'h0, `GSC_RESP_SLVERR);
		rd(8'h05, 32'hFFFFFFFF, 32'h0, `GSC_RESP_SLVERR);
		wr(8'h30, 32'h1, `GSC_RESP_SLVERR);
		wr(`GSC_OFF_LIM_V, 32'h0);
		rd(`GSC_OFF_STAT, 32'h3, 32'h0);
		wr(`GSC_OFF_CTRL, 32'h1);
		quiet(14'h0010, 20);
		wr(`GSC_OFF_LIM_V, 32'h100);
		rd(`GSC_OFF_STAT, 32'h3, 32'h1);
	endtask
	task automatic t_volt;
		wr(`GSC_OFF_VBASE, 32'h4);
		set_gen(-16'h200, 16'h0, 16'h0);
		wait_bit(VOK, 0, 5);
		wr(`GSC_OFF_CTRL, 32'h1);
		wait_bit(RUN, 1, 5);
		rd(`GSC_OFF_STAT, 32'h3, 32'h2);
		wait_bit(RV, 1, 20);
		chk("LOWER_V", 32'h0, 32'(LOWER_V));
		plen(RV, 325, 375);
		wait_bit(CLS, 1, 800);
		chk("VOLT_OK", 32'h1, 32'(VOLT_OK));
		plen(CLS, 980, 1005);
		wait_bit(RUN, 0, 1200);
		quiet(CMDS, 300);
		chk("close count", 32'h1, 32'(n_close));
	endtask
	task automatic t_freq;
		wr(`GSC_OFF_FBASE, 32'h8);
		set_gen(16'h0, 16'd20, 16'h0);
		wr(`GSC_OFF_CTRL, 32'h1);
		wait_bit(LF, 1, 30);
		chk("RAISE_F", 32'h0, 32'(RAISE_F));
		plen(LF, 80, 115);
		wr(`GSC_OFF_CTRL, 32'h2);
		wait_bit(RUN, 0, 5);
		quiet(CMDS, 20);
		set_gen(16'h0, -16'd20, 16'h0);
		wr(`GSC_OFF_CTRL, 32'h1);
		wait_bit(RF, 1, 30);
		chk("LOWER_F", 32'h0, 32'(LOWER_F));
		wr(`GSC_OFF_CTRL, 32'h2);
		wait_bit(RUN, 0, 5);
	endtask
	task automatic t_pos;
		set_gen(16'h0, -16'd2, 16'h0);
		wait_bit(FOK, 1, 5);
		wr(`GSC_OFF_CTRL, 32'h5);
		wait_bit(FOK, 0, 5);
		load <= 1'b1; // Keep reverse slip so governor pulses cannot cure it
		quiet(14'h0400, 100);
		wr(`GSC_OFF_CTRL, 32'h6);
		set_gen(16'h0, 16'd2, 16'h0);
		wait_bit(FOK, 1, 5);
		wr(`GSC_OFF_CTRL, 32'h0);
	endtask
	task automatic t_pre;
		set_gen(16'h0, 16'd5, -16'h300);
		wait_bit(AOK, 0, 5);
		wait_bit(ENC, 1, 5);
		wr(`GSC_OFF_PRECL, 32'h0);
		wr(`GSC_OFF_CTRL, 32'h1);
		quiet(14'h0400, 200);
		wr(`GSC_OFF_CTRL, 32'h2);
		wr(`GSC_OFF_PRECL, 32'h32);
		wr(`GSC_OFF_CTRL, 32'h1);
		wait_bit(CLS, 1, 20);
		chk("ANGLE_OK", 32'h0, 32'(ANGLE_OK));
		wait_bit(RUN, 0, 1200);
		MEAS_VLD <= 1'b0;
		set_gen(16'h0, 16'd5, 16'h100);
		quiet(14'h1000, 5);
		MEAS_VLD <= 1'b1;
		wait_bit(DEP, 1, 5);
		set_gen(16'h0, 16'h0, 16'h100);
		wait_bit(STL, 1, 5);
	endtask
	task automatic t_block;
		set_gen(16'h200, 16'h0, 16'h0);
		wr(`GSC_OFF_CTRL, 32'h1);
		wait_bit(LV, 1, 20);
		chk("RAISE_V", 32'h0, 32'(RAISE_V));
		BLOCK_IN <= 1'b1;
		wait_bit(BLK, 1, 5);
		wait_bit(LV, 0, 4);
		chk("RUNNING", 32'h0, 32'(RUNNING));
		rd(`GSC_OFF_STAT, 32'h3, 32'h3);
		wr(`GSC_OFF_CTRL, 32'h1);
		quiet(14'h07D0, 30);
		BLOCK_IN <= 1'b0;
		wait_bit(BLK, 0, 6);
		quiet(14'h0010, 10);
		wr(`GSC_OFF_CTRL, 32'h8);
		wait_bit(BLK, 1, 5);
		wr(`GSC_OFF_CTRL, 32'h0);
		wait_bit(BLK, 0, 5);
	endtask
	task automatic t_long;
		set_gen(16'h0, 16'h0, 16'h4000);
		wr(`GSC_OFF_SYNCT, 32'h3);
		wr(`GSC_OFF_CTRL, 32'h1);
		chk("LONG_SYNC", 32'h0, 32'(LONG_SYNC));
		wait_bit(LNG, 1, 60);
		rd(`GSC_OFF_LEFT, 32'hFFFFFFFF, 32'h0);
		wr(`GSC_OFF_CTRL, 32'h2);
		wait_bit(RUN, 0, 5);
		chk("LONG_SYNC", 32'h1, 32'(LONG_SYNC));
		wr(`GSC_OFF_CTRL, 32'h1);
		wait_bit(LNG, 0, 5);
		wr(`GSC_OFF_CTRL, 32'h2);
	endtask
	// ============================================================
	// Main sequence
	initial begin
		repeat (5) @(posedge CLK_SYS);
		NRST <= 1'b1;
		@(posedge CLK_SYS);
		t_regs;
		t_volt;
		t_freq;
		t_pos;
		t_pre;
		t_block;
		t_long;
		test_done;
	end
endmodule
